// File: dv/pcd_radio_model.sv
// Purpose: synthesizer model answering calibration requests
// Assumes: start request is a one-cycle pulse
// Notes:   fixed latency, slower than short delays on purpose
`timescale 1ns/1ps

module pcd_radio_model
#(
    parameter int unsigned CAL_CYCLES = 200
)
(
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    // synthesizer handshake
    input  wire logic synth_cal_start_in,
    output logic      synth_cal_done_out
);
    // ==========================================================
    // calibration timer
    int unsigned cnt;

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cnt                <= 0;
            synth_cal_done_out <= 1'b0;
        end
        else
        begin
            // calibration and settling take CAL_CYCLES
            if (synth_cal_start_in)
                cnt <= CAL_CYCLES;
            else if (cnt != 0)
                cnt <= cnt - 1;
            synth_cal_done_out <= (cnt == 1);
        end
    end
endmodule // pcd_radio_model

// File: dv/pcd_top_asserts.sv
// Purpose: port assertions for pcd_top
// Assumes: mode_fsk_in steady while a delay runs
// Notes:   delay lengths are measured by the bench, not here
`timescale 1ns/1ps

module pcd_top_asserts
(
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    // radio controller
    input  wire logic mode_fsk_in,
    input  wire logic receive_command_in,
    input  wire logic transmit_command_in,
    input  wire logic frame_received_in,
    input  wire logic synth_cal_start_out,
    input  wire logic rx_search_start_out,
    input  wire logic rssi_window_start_out,
    input  wire logic tx_enter_out,
    input  wire logic delay_busy_out,
    input  wire logic pkt_received_irq_out,
    // packet manager controls
    input  wire logic rx_check_en_out,
    input  wire logic rx_fcs_replace_out,
    input  wire logic rx_store_raw_out,
    input  wire logic tx_check_gen_out
);
    // ==========================================================
    // properties
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    irq_follow_a: assert property (
        pkt_received_irq_out == $past(frame_received_in))
        else $error("irq does not follow frame event");
    busy_start_a: assert property (
        (receive_command_in || transmit_command_in) && !delay_busy_out
        |=> delay_busy_out)
        else $error("accepted command did not start a delay");
    end_clears_a: assert property (
        (rx_search_start_out || tx_enter_out) |-> !delay_busy_out)
        else $error("end pulse while still busy");
    busy_fell_a: assert property (
        $fell(delay_busy_out) |-> rx_search_start_out || tx_enter_out)
        else $error("delay ended without end pulse");
    rssi_mode_a: assert property (
        rssi_window_start_out == (rx_search_start_out && !$past(mode_fsk_in)))
        else $error("rssi window pulse wrong for mode");
    tx_single_a: assert property (
        tx_enter_out |=> !tx_enter_out)
        else $error("transmit entry pulse too long");
    cal_first_a: assert property (
        synth_cal_start_out |-> delay_busy_out && !$past(delay_busy_out))
        else $error("calibration start outside delay start");
    fcs_pair_a: assert property (
        rx_store_raw_out == !rx_check_en_out
        && tx_check_gen_out == rx_check_en_out)
        else $error("fcs controls disagree");
    fcs_repl_a: assert property (
        $past(reset_n_in) |->
        rx_fcs_replace_out == (rx_check_en_out && !$past(mode_fsk_in)))
        else $error("fcs replace wrong for mode");
endmodule // pcd_top_asserts

bind pcd_top pcd_top_asserts u_asserts (.sys_clk_in, .reset_n_in,
    .mode_fsk_in, .receive_command_in, .transmit_command_in,
    .frame_received_in, .synth_cal_start_out, .rx_search_start_out,
    .rssi_window_start_out, .tx_enter_out, .delay_busy_out,
    .pkt_received_irq_out, .rx_check_en_out, .rx_fcs_replace_out,
    .rx_store_raw_out, .tx_check_gen_out);

// File: dv/pcd_top_tb_top.sv
// Purpose: self-checking bench of pcd_top
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes:   calibration latency comes from pcd_radio_model
`timescale 1ns/1ps

module pcd_top_tb_top;
    // ==========================================================
    // signals
    localparam int unsigned CAL = 200;
    logic        sys_clk_in, reset_n_in, reg_wr_en_in, reg_rd_en_in;
    logic [9:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in, reg_rdata_out;
    logic        mode_fsk_in, receive_command_in, transmit_command_in;
    logic        synth_cal_done_in, frame_received_in, synth_cal_start_out;
    logic        rx_search_start_out, rssi_window_start_out, tx_enter_out;
    logic        delay_busy_out, pkt_received_irq_out, rx_check_en_out;
    logic        rx_fcs_replace_out, rx_store_raw_out, tx_check_gen_out;
    logic        addon_enable_out;
    logic [23:0] sync_word_out;
    int          miscompares = 0;
    int          tests_run   = 0;

    pcd_top uut (.sys_clk_in, .reset_n_in, .reg_wr_en_in, .reg_rd_en_in,
        .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .mode_fsk_in,
        .receive_command_in, .transmit_command_in, .synth_cal_done_in,
        .frame_received_in, .synth_cal_start_out, .rx_search_start_out,
        .rssi_window_start_out, .tx_enter_out, .delay_busy_out,
        .pkt_received_irq_out, .rx_check_en_out, .rx_fcs_replace_out,
        .rx_store_raw_out, .tx_check_gen_out, .addon_enable_out,
        .sync_word_out);
    pcd_radio_model #(.CAL_CYCLES(CAL)) u_radio (.sys_clk_in,
        .reset_n_in, .synth_cal_start_in(synth_cal_start_out),
        .synth_cal_done_out(synth_cal_done_in));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // ==========================================================
    // shared tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [23:0] e,
                       input logic [23:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_en_in = 1'b1;
        @(negedge sys_clk_in);
        reg_wr_en_in = 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_rd_en_in = 1'b1;
        @(negedge sys_clk_in);
        reg_rd_en_in = 1'b0;
        chk("reg_rdata_out", 24'(e), 24'(reg_rdata_out));
    endtask

    // cycles counted from the edge that takes the command
    task automatic run_cmd(input logic tx, output int c, output logic cal);
        c = 0;
        cal = 1'b0;
        @(negedge sys_clk_in);
        if (tx)
            transmit_command_in = 1'b1;
        else
            receive_command_in = 1'b1;
        do
        begin
            @(negedge sys_clk_in);
            receive_command_in = 1'b0;
            transmit_command_in = 1'b0;
            c++;
            cal |= synth_cal_start_out;
        end
        while (!(rx_search_start_out | tx_enter_out) && c < 20000);
        if (c >= 20000)
        begin
            miscompares++;
            close_out();
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] rv [8] = '{8'h00, pcd_pkg::RST_PKT_CFG, 8'hc0, 8'hc0,
                               8'h00, 8'h31, 8'h7a, 8'haa};
        for (int i = 0; i < 8; i++)
            rd_chk(10'h107 + 10'(i), rv[i]);
        rd_chk(10'h110, 8'h00);
        chk("sync_word_out", 24'haa7a31, sync_word_out);
        $display("t_reset done");
    endtask

    task automatic t_rw();
        for (int i = 0; i < 8; i++)
            wr_reg(10'h107 + 10'(i), 8'(8'h11 * (i + 1)));
        wr_reg(10'h110, 8'hff);
        for (int i = 0; i < 8; i++)
            rd_chk(10'h107 + 10'(i), 8'(8'h11 * (i + 1)));
        rd_chk(10'h110, 8'h00);
        chk("sync_word_out", 24'h887766, sync_word_out);
        $display("t_rw done");
    endtask

    task automatic t_delay();
        int         c;
        logic       cal;
        int         e;
        int         tab [5][5] = '{'{0, 0, 3, 1, 0}, '{1, 0, 2, 0, 0},
            '{1, 1, 0, 2, 0}, '{0, 1, 4, 0, 0}, '{0, 0, 5, 0, 1}};
        // skip bit only as in continuous transmission
        wr_reg(pcd_pkg::OFS_PKT_CFG, 8'h0c);
        foreach (tab[i])
        begin
            mode_fsk_in = tab[i][1][0];
            wr_reg(pcd_pkg::OFS_BUFFER_CFG, tab[i][4] ? 8'h80 : 8'h00);
            wr_reg(tab[i][0] ? pcd_pkg::OFS_TX_DELAY
                   : pcd_pkg::OFS_RX_DELAY, 8'(tab[i][2]));
            wr_reg(pcd_pkg::OFS_DELAY_EXT, 8'(tab[i][3]));
            run_cmd(tab[i][0][0], c, cal);
            e = tab[i][4] ? 2 : (tab[i][2] + 4 * tab[i][3]) * 25 + 2;
            chk("cycles", 24'(e),
                24'(c));
            chk("tx_enter_out", 24'(tab[i][0]), 24'(tx_enter_out));
            chk("rx_search_start_out", 24'(!tab[i][0]),
                24'(rx_search_start_out));
            chk("delay_busy_out", 24'h0, 24'(delay_busy_out));
            chk("rssi_window_start_out", 24'(!tab[i][0] && !tab[i][1]),
                24'(rssi_window_start_out));
            chk("synth_cal_start_out", 24'h0, 24'(cal));
        end
        $display("t_delay done");
    endtask

    task automatic t_cal();
        int   c;
        logic cal;
        mode_fsk_in = 1'b0;
        wr_reg(pcd_pkg::OFS_PKT_CFG, 8'h04);
        wr_reg(pcd_pkg::OFS_BUFFER_CFG, 8'h00);
        wr_reg(pcd_pkg::OFS_TX_DELAY, 8'h02);
        wr_reg(pcd_pkg::OFS_DELAY_EXT, 8'h00);
        run_cmd(1'b1, c, cal);
        chk("synth_cal_start_out", 24'h1, 24'(cal));
        chk("cal wait", 24'h1, 24'(c > CAL && c < CAL + 8));
        $display("t_cal done");
    endtask

    task automatic t_fcs();
        for (int i = 0; i < 4; i++)
        begin
            mode_fsk_in = i[1];
            // extension image taken as loaded before bit 4
            wr_reg(pcd_pkg::OFS_PKT_CFG, {3'h0, i[0], 1'h0, 2'h2, i[0]});
            @(negedge sys_clk_in);
            @(negedge sys_clk_in);
            chk("rx_check_en_out", 24'(!i[0]),
                24'(rx_check_en_out));
            chk("rx_store_raw_out", 24'(i[0]),
                24'(rx_store_raw_out));
            chk("tx_check_gen_out", 24'(!i[0]),
                24'(tx_check_gen_out));
            chk("rx_fcs_replace_out", 24'(!i[0] && !i[1]),
                24'(rx_fcs_replace_out));
            chk("addon_enable_out", 24'(i[0]),
                24'(addon_enable_out));
            frame_received_in = 1'b1;
            @(negedge sys_clk_in);
            frame_received_in = 1'b0;
            chk("pkt_received_irq_out", 24'h1,
                24'(pkt_received_irq_out));
        end
        mode_fsk_in = 1'b0;
        $display("t_fcs done");
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        reset_n_in = 1'b0;
        reg_wr_en_in = 1'b0;
        reg_rd_en_in = 1'b0;
        reg_addr_in = 10'h000;
        reg_wdata_in = 8'h00;
        mode_fsk_in = 1'b0;
        receive_command_in = 1'b0;
        transmit_command_in = 1'b0;
        frame_received_in = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        t_reset();
        t_rw();
        t_delay();
        t_cal();
        t_fcs();
        close_out();
    end
endmodule // pcd_top_tb_top

// File: rtl/pcd_pkg.sv
// Purpose: shared constants and types of the packet config and delay block
// Assumes: 25 MHz device clock, byte-wide register port
// Notes:   register offsets are the device's own register addresses
package pcd_pkg;

    // ==========================================================
    // register port
    localparam int unsigned ADDR_W   = 10;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned NUM_REGS = 8;

    localparam logic [9:0] OFS_BUFFER_CFG = 10'h107;
    localparam logic [9:0] OFS_PKT_CFG    = 10'h108;
    localparam logic [9:0] OFS_RX_DELAY   = 10'h109;
    localparam logic [9:0] OFS_TX_DELAY   = 10'h10a;
    localparam logic [9:0] OFS_DELAY_EXT  = 10'h10b;
    localparam logic [9:0] OFS_SYNC_LOW   = 10'h10c;
    localparam logic [9:0] OFS_SYNC_MID   = 10'h10d;
    localparam logic [9:0] OFS_SYNC_HIGH  = 10'h10e;

    // ==========================================================
    // values after reset
    localparam logic [7:0] RST_BUFFER_CFG = 8'h00;
    localparam logic [7:0] RST_PKT_CFG    = 8'h04;
    localparam logic [7:0] RST_RX_DELAY   = 8'hc0;
    localparam logic [7:0] RST_TX_DELAY   = 8'hc0;
    localparam logic [7:0] RST_DELAY_EXT  = 8'h00;
    localparam logic [7:0] RST_SYNC_LOW   = 8'h31;
    localparam logic [7:0] RST_SYNC_MID   = 8'h7a;
    localparam logic [7:0] RST_SYNC_HIGH  = 8'haa;
    localparam logic [7:0] RST_RDATA      = 8'h00;

    // ==========================================================
    // field positions
    localparam int unsigned BIT_DELAY_OFF   = 7;
    localparam int unsigned BIT_ADDON_EN    = 4;
    localparam int unsigned BIT_SKIP_SETTLE = 3;
    localparam int unsigned BIT_FCS_OFF     = 0;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned US_NS         = 1000;
    localparam int unsigned TICK_CYCLES   = US_NS / CLK_PERIOD_NS;
    localparam int unsigned EXT_STEP_US   = 4;
    localparam int unsigned TICK_W        = 5;
    localparam int unsigned US_W          = 11;
    localparam logic [4:0]  TICK_LAST     = 5'(TICK_CYCLES - 1);

    // ==========================================================
    // types
    typedef struct packed {
        logic [7:0]  buffer_cfg;
        logic [7:0]  pkt_cfg;
        logic [7:0]  rx_delay;
        logic [7:0]  tx_delay;
        logic [7:0]  delay_ext;
        logic [23:0] sync_word;
    } pcd_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } pcd_state_e;

endpackage : pcd_pkg

// File: rtl/pcd_regs.sv
// Purpose: byte register file of the packet config and delay block
// Assumes: one access per cycle, write and read strobes synchronous
// Notes:   read data come out of a register one cycle after the strobe
`timescale 1ns/1ps

module pcd_regs
(
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_n_in,
    // register port
    input  wire logic                 wr_en_in,
    input  wire logic                 rd_en_in,
    input  wire logic [9:0]           addr_in,
    input  wire logic [7:0]           wdata_in,
    output logic      [7:0]           rdata_out,
    // stored fields
    output pcd_pkg::pcd_cfg_s         cfg_out
);

    // ==========================================================
    // decode
    function automatic logic in_map(input logic [9:0] a);
        in_map = (a >= pcd_pkg::OFS_BUFFER_CFG) &&
                 (a <= pcd_pkg::OFS_SYNC_HIGH);
    endfunction

    function automatic logic [2:0] index_of(input logic [9:0] a);
        logic [9:0] d;
        d = a - pcd_pkg::OFS_BUFFER_CFG;
        index_of = d[2:0];
    endfunction

    logic [7:0] mem      [pcd_pkg::NUM_REGS];
    logic [7:0] next_mem [pcd_pkg::NUM_REGS];
    logic [7:0] next_rdata;

    // ==========================================================
    // next values
    always_comb
    begin
        for (int i = 0; i < pcd_pkg::NUM_REGS; i++)
            next_mem[i] = mem[i];
        next_rdata = rdata_out;
        if (wr_en_in && in_map(addr_in))
            next_mem[index_of(addr_in)] = wdata_in;
        // unmapped reads answer zero
        if (rd_en_in)
            next_rdata = in_map(addr_in) ? mem[index_of(addr_in)]
                                         : pcd_pkg::RST_RDATA;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mem[0]    <= pcd_pkg::RST_BUFFER_CFG;
            mem[1]    <= pcd_pkg::RST_PKT_CFG;
            mem[2]    <= pcd_pkg::RST_RX_DELAY;
            mem[3]    <= pcd_pkg::RST_TX_DELAY;
            mem[4]    <= pcd_pkg::RST_DELAY_EXT;
            mem[5]    <= pcd_pkg::RST_SYNC_LOW;
            mem[6]    <= pcd_pkg::RST_SYNC_MID;
            mem[7]    <= pcd_pkg::RST_SYNC_HIGH;
            rdata_out <= pcd_pkg::RST_RDATA;
        end
        else
        begin
            for (int i = 0; i < pcd_pkg::NUM_REGS; i++)
                mem[i] <= next_mem[i];
            rdata_out <= next_rdata;
        end
    end

    assign cfg_out.buffer_cfg = mem[0];
    assign cfg_out.pkt_cfg    = mem[1];
    assign cfg_out.rx_delay   = mem[2];
    assign cfg_out.tx_delay   = mem[3];
    assign cfg_out.delay_ext  = mem[4];
    assign cfg_out.sync_word  = {mem[7], mem[6], mem[5]}; // see [R15] [R17]

endmodule // pcd_regs

// File: rtl/pcd_top.sv
// Purpose: packet handling config, command delays and sync pattern
// Assumes: commands and frame events are one-cycle pulses on sys_clk_in
// Notes:   commands that arrive while a delay runs are dropped
//
// Contract
// [R1] host loads the extension module before setting the extension-enable bit
// [R2] skip bit set skips synth calibration and settling, else performed
// [R3] host sets the skip bit only in continuous packet transmission mode
// [R4] packet-received interrupt raised in both packet modes, any fcs setting
// [R5] 802.15.4, bit0 clear: check fcs, replace it with rssi and quality
// [R6] 802.15.4, bit0 clear: generate and append fcs, ignore buffer fcs
// [R7] 802.15.4, bit0 set: store received fcs unchanged, no check
// [R8] 802.15.4, bit0 set: transmit fcs bytes from transmit buffer
// [R9] fsk, bit0 clear: check received crc, append generated crc on transmit
// [R10] fsk, bit0 set: store received crc unchecked, send buffer crc
// [R11] 802.15.4: receive delay before frame search and rssi window, reset 192
// [R12] fsk: receive delay in microseconds before sync word search
// [R13] transmit delay before entering transmit, 1 us units, reset 192
// [R14] both delays lengthened by extension times 4 us, reset zero
// [R15] sync bits [7:0] and [15:8] from two byte registers, 49 and 122
// [R16] buffer config bit 7 set disables both command delays
// [R17] sync bits [23:16] in a third byte register, reset 170
// [R18] delay equals base plus four times extension, timed by microsecond tick
`timescale 1ns/1ps

module pcd_top
(
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_n_in,
    // register port
    input  wire logic                 reg_wr_en_in,
    input  wire logic                 reg_rd_en_in,
    input  wire logic [9:0]           reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    output logic      [7:0]           reg_rdata_out,
    // radio controller
    input  wire logic                 mode_fsk_in,
    input  wire logic                 receive_command_in,
    input  wire logic                 transmit_command_in,
    input  wire logic                 synth_cal_done_in,
    input  wire logic                 frame_received_in,
    output logic                      synth_cal_start_out,
    output logic                      rx_search_start_out,
    output logic                      rssi_window_start_out,
    output logic                      tx_enter_out,
    output logic                      delay_busy_out,
    output logic                      pkt_received_irq_out,
    // packet manager controls
    output logic                      rx_check_en_out,
    output logic                      rx_fcs_replace_out,
    output logic                      rx_store_raw_out,
    output logic                      tx_check_gen_out,
    output logic                      addon_enable_out,
    output logic      [23:0]          sync_word_out
);

    // ==========================================================
    // registers
    pcd_pkg::pcd_cfg_s cfg;

    pcd_regs u_regs
    (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .wr_en_in   (reg_wr_en_in),
        .rd_en_in   (reg_rd_en_in),
        .addr_in    (reg_addr_in),
        .wdata_in   (reg_wdata_in),
        .rdata_out  (reg_rdata_out),
        .cfg_out    (cfg)
    );

    // delay in microseconds, zero when delays are switched off
    function automatic logic [10:0] delay_us(
        input logic [7:0] base,
        input logic [7:0] ext,
        input logic       off
    );
        logic [10:0] sum;
        sum = {3'h0, base} +
              11'({3'h0, ext} * 11'(pcd_pkg::EXT_STEP_US)); // see [R18] [R14]
        delay_us = off ? 11'h000 : sum; // see [R16]
    endfunction

    // ==========================================================
    // configuration flags
    logic fcs_off;
    logic delay_off;
    logic skip_settle;

    assign fcs_off     = cfg.pkt_cfg[pcd_pkg::BIT_FCS_OFF];
    assign delay_off   = cfg.buffer_cfg[pcd_pkg::BIT_DELAY_OFF];
    // the skip is honoured as set; legality of the mode rests with the host
    assign skip_settle = cfg.pkt_cfg[pcd_pkg::BIT_SKIP_SETTLE]; // see [R3]

    logic        next_rx_check;
    logic        next_rx_replace;
    logic        next_rx_raw;
    logic        next_tx_gen;
    logic        next_addon;
    logic [23:0] next_sync;
    logic        next_irq;

    always_comb
    begin
        // fcs in 802.15.4, crc in fsk: same switch, only the swap differs
        next_rx_check   = !fcs_off;                  // see [R5] [R9]
        next_rx_replace = !fcs_off && !mode_fsk_in;  // see [R5]
        next_rx_raw     = fcs_off;                   // see [R7] [R10]
        next_tx_gen     = !fcs_off;          // see [R6] [R8] [R9] [R10]
        // the enable is passed on as is; loading first is the host's duty
        next_addon      = cfg.pkt_cfg[pcd_pkg::BIT_ADDON_EN]; // see [R1]
        next_sync       = cfg.sync_word;            // see [R15] [R17]
        next_irq        = frame_received_in;        // see [R4]
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rx_check_en_out      <= 1'b1;
            rx_fcs_replace_out   <= 1'b1;
            rx_store_raw_out     <= 1'b0;
            tx_check_gen_out     <= 1'b1;
            addon_enable_out     <= 1'b0;
            sync_word_out        <= {pcd_pkg::RST_SYNC_HIGH,
                                     pcd_pkg::RST_SYNC_MID,
                                     pcd_pkg::RST_SYNC_LOW};
            pkt_received_irq_out <= 1'b0;
        end
        else
        begin
            rx_check_en_out      <= next_rx_check;
            rx_fcs_replace_out   <= next_rx_replace;
            rx_store_raw_out     <= next_rx_raw;
            tx_check_gen_out     <= next_tx_gen;
            addon_enable_out     <= next_addon;
            sync_word_out        <= next_sync;
            pkt_received_irq_out <= next_irq;
        end
    end

    // ==========================================================
    // command delay sequencer
    pcd_pkg::pcd_state_e state;
    pcd_pkg::pcd_state_e next_state;
    logic        is_rx;
    logic        next_is_rx;
    logic        cal_pending;
    logic        next_cal_pending;
    logic [10:0] us_left;
    logic [10:0] next_us_left;
    logic [4:0]  tick_cnt;
    logic [4:0]  next_tick_cnt;
    logic        next_cal_start;
    logic        next_rx_start;
    logic        next_rssi_start;
    logic        next_tx_enter;

    always_comb
    begin
        next_state       = state;
        next_is_rx       = is_rx;
        next_cal_pending = cal_pending;
        next_us_left     = us_left;
        next_tick_cnt    = tick_cnt;
        next_cal_start   = 1'b0;
        next_rx_start    = 1'b0;
        next_rssi_start  = 1'b0;
        next_tx_enter    = 1'b0;
        case (state)
            pcd_pkg::ST_IDLE:
            begin
                if (receive_command_in || transmit_command_in)
                begin
                    // receive wins when both arrive together
                    next_is_rx       = receive_command_in;
                    next_us_left     = receive_command_in
                        ? delay_us(cfg.rx_delay, cfg.delay_ext,
                                   delay_off)         // see [R11] [R12]
                        : delay_us(cfg.tx_delay, cfg.delay_ext,
                                   delay_off);        // see [R13]
                    next_tick_cnt    = 5'h00;
                    next_cal_pending = !skip_settle;  // see [R2]
                    next_cal_start   = !skip_settle;  // see [R2]
                    next_state       = pcd_pkg::ST_WAIT;
                end
            end
            pcd_pkg::ST_WAIT:
            begin
                if (synth_cal_done_in)
                    next_cal_pending = 1'b0;
                // microsecond tick from the 25 MHz clock
                if (us_left != 11'h000)
                begin
                    if (tick_cnt == pcd_pkg::TICK_LAST) // see [R18]
                    begin
                        next_tick_cnt = 5'h00;
                        next_us_left  = us_left - 11'h001;
                    end
                    else
                        next_tick_cnt = tick_cnt + 5'h01;
                end
                else if (!cal_pending)
                begin
                    next_rx_start   = is_rx;                 // see [R11] [R12]
                    next_rssi_start = is_rx && !mode_fsk_in; // see [R11]
                    next_tx_enter   = !is_rx;                // see [R13]
                    next_state      = pcd_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = pcd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state                 <= pcd_pkg::ST_IDLE;
            is_rx                 <= 1'b0;
            cal_pending           <= 1'b0;
            us_left               <= 11'h000;
            tick_cnt              <= 5'h00;
            synth_cal_start_out   <= 1'b0;
            rx_search_start_out   <= 1'b0;
            rssi_window_start_out <= 1'b0;
            tx_enter_out          <= 1'b0;
        end
        else
        begin
            state                 <= next_state;
            is_rx                 <= next_is_rx;
            cal_pending           <= next_cal_pending;
            us_left               <= next_us_left;
            tick_cnt              <= next_tick_cnt;
            synth_cal_start_out   <= next_cal_start;
            rx_search_start_out   <= next_rx_start;
            rssi_window_start_out <= next_rssi_start;
            tx_enter_out          <= next_tx_enter;
        end
    end

    // commands seen while busy are dropped, so the host should watch this
    assign delay_busy_out = (state == pcd_pkg::ST_WAIT);

endmodule // pcd_top
